/* File: tb/htsr_engine_model.sv */
// Task engine model: answers each task start after a set delay.
// Assumes the bench sets outcome, payload and delay before the start.
`timescale 1ns/1ps
`default_nettype none
module htsr_engine_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Scenario setup
  input wire logic [15:0] cfg_delay,
  input wire logic [3:0] cfg_outcome,
  input wire logic [3:0] cfg_hi,
  input wire logic [55:0] cfg_payload,
  // Bank side
  input wire logic task_start,
  output logic task_done,
  output logic [3:0] task_outcome,
  output logic [3:0] task_code_hi,
  output logic [55:0] task_payload,
  output logic busy
);
  logic [15:0] left;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      task_done <= 1'b0;
      left <= 16'h0;
    end else begin
      task_done <= busy && left == 16'h1;
      if (task_start) begin
        busy <= 1'b1;
        left <= cfg_delay;
      end else if (busy) begin
        left <= left - 16'h1;
        busy <= left != 16'h1;
      end
    end
  end
  // Results hold no meaning outside the done pulse, so they are scrambled there
  assign task_outcome = task_done ? cfg_outcome : ~cfg_outcome;
  assign task_code_hi = task_done ? cfg_hi : ~cfg_hi;
  assign task_payload = task_done ? cfg_payload : ~cfg_payload;
endmodule
`default_nettype wire

/* File: tb/htsr_regs_properties.sv */
// Port checker for the host task register bank.
// Assumes it is bound to each bank instance and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module htsr_regs_chk (
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [63:0] reg_rdata,
  // Task, pins and power
  input wire logic [31:0] task_cmd,
  input wire logic task_done,
  input wire logic task_needs_rx,
  input wire logic rx_buf_locked,
  input wire logic [htsr_pkg::HTSR_NUM_PINS-1:0] pin_level_in,
  input wire logic [htsr_pkg::HTSR_NUM_PINS-1:0] pin_dir_out,
  input wire logic sleep_enter
);
  import htsr_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Mirror of the permit bit, rebuilt from the bus writes alone
  logic permit_seen;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      permit_seen <= HTSR_SLEEP_CFG_RST[HTSR_PERMIT_BIT];
    end else if (reg_wr && reg_addr == HTSR_ADDR_SLEEP_CFG) begin
      permit_seen <= reg_wdata[HTSR_PERMIT_BIT];
    end
  end
  property p_permit_hold;
    !permit_seen && !$past(permit_seen) |-> !sleep_enter;
  endproperty
  a_permit_hold: assert property (p_permit_hold) else $error("sleep while not permitted");
  property p_permit_off;
    reg_wr && reg_addr == HTSR_ADDR_SLEEP_CFG && !reg_wdata[0] |-> ##2 (!sleep_enter) [*4];
  endproperty
  a_permit_off: assert property (p_permit_off) else $error("sleep not permitted");
  property p_cfg_resv;
    $past(reg_rd) && $past(reg_addr) == HTSR_ADDR_SLEEP_CFG |-> reg_rdata[63:1] == 63'h0;
  endproperty
  a_cfg_resv: assert property (p_cfg_resv) else $error("setup reserved bits");
  property p_pin_resv;
    $past(reg_rd) && $past(reg_addr) == HTSR_ADDR_PIN_STATE |-> reg_rdata[63:41] == 23'h0
      && reg_rdata[31:13] == 19'h0 && reg_rdata[11:9] == 3'h0;
  endproperty
  a_pin_resv: assert property (p_pin_resv) else $error("pin reserved bits");
  // Pads pass a synchronizer, so only a settled pin is compared
  property p_pin_dir;
    ($stable(pin_dir_out) && $stable(pin_level_in)) [*8] ##1
      (reg_rd && reg_addr == HTSR_ADDR_PIN_STATE && $stable(pin_dir_out))
      |=> reg_rdata[40:32] == $past(pin_dir_out[8:0]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction");
  property p_pin_lvl;
    ($stable(pin_dir_out) && $stable(pin_level_in)) [*8] ##1
      (reg_rd && reg_addr == HTSR_ADDR_PIN_STATE && $stable(pin_level_in))
      |=> reg_rdata[12] == $past(pin_level_in[12]) && reg_rdata[8:0] == $past(pin_level_in[8:0]);
  endproperty
  a_pin_lvl: assert property (p_pin_lvl) else $error("pin level");
  property p_done_clear;
    task_done && task_cmd != 32'h0 |-> ##[1:3] task_cmd == 32'h0;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("command not cleared");
  property p_rx_locked;
    task_needs_rx && rx_buf_locked && task_cmd != 32'h0 |-> ##[1:3] task_cmd == 32'h0;
  endproperty
  a_rx_locked: assert property (p_rx_locked) else $error("locked task not ended");
  property p_hi_nibble;
    $past(reg_rd) && $past(reg_addr) == HTSR_ADDR_DATA && reg_rdata[3:0] inside {[4'h1:4'h4]}
      |-> reg_rdata[7:4] == 4'h0;
  endproperty
  a_hi_nibble: assert property (p_hi_nibble) else $error("status upper nibble");
endmodule
bind htsr_regs htsr_regs_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .task_cmd(task_cmd), .task_done(task_done), .task_needs_rx(task_needs_rx),
  .rx_buf_locked(rx_buf_locked), .pin_level_in(pin_level_in), .pin_dir_out(pin_dir_out),
  .sleep_enter(sleep_enter));
`default_nettype wire

/* File: tb/tb_htsr_regs.sv */
// Self-checking bench for the host task register bank.
// Assumes the package, the bank, its checker and the engine model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_htsr_regs;
  import htsr_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [63:0] reg_wdata = 64'h0, reg_rdata, q, b;
  logic reg_wr = 1'b0, reg_rd = 1'b0, needs_rx = 1'b0, rx_lock = 1'b0;
  logic task_start, task_done, busy, sleep_enter, irq;
  logic [31:0] task_cmd;
  logic [3:0] t_out, t_hi, cf_out = 4'h0, cf_hi = 4'h0;
  logic [55:0] t_pay, cf_pay = 56'h0;
  logic [15:0] cf_dly = 16'h0014;
  logic [12:0] lvl = 13'h0, dir = 13'h0;
  logic [63:0] exp_q[$];
  int oc[6] = '{0, 1, 3, 4, 5, 15};
  int n_errors = 0, checks_done = 0, k;
  htsr_regs DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .task_cmd(task_cmd), .task_start(task_start), .task_done(task_done),
    .task_outcome(t_out), .task_code_hi(t_hi), .task_payload(t_pay),
    .task_needs_rx(needs_rx), .rx_buf_locked(rx_lock), .task_activity(busy),
    .pin_level_in(lvl), .pin_dir_out(dir), .sleep_enter(sleep_enter), .irq(irq));
  htsr_engine_model u_eng (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_delay(cf_dly),
    .cfg_outcome(cf_out), .cfg_hi(cf_hi), .cfg_payload(cf_pay), .task_start(task_start),
    .task_done(task_done), .task_outcome(t_out), .task_code_hi(t_hi),
    .task_payload(t_pay), .busy(busy));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_cmd();
    int j;
    for (j = 0; j < 100; j++) begin
      rd(HTSR_ADDR_CMD);
      if (q[31:0] === 32'h0) break;
    end
    `CHK("cmd_clear", 32'h0, q[31:0])
    if (j == 100) close_out();
  endtask
  initial begin
    k = $urandom(66944);
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(HTSR_ADDR_SLEEP_CFG);
    `CHK("cfg_reset", HTSR_SLEEP_CFG_RST, q[7:0])
    wr(HTSR_ADDR_SLEEP_CFG, 64'hfe);
    wr(HTSR_ADDR_IDLE_TIME, 64'h1);
    rd(HTSR_ADDR_SLEEP_CFG);
    `CHK("cfg_resv", 8'h00, q[7:0])
    repeat (300) @(posedge sys_clk);
    #1 `CHK("no_sleep", 1'b0, sleep_enter)
    wr(HTSR_ADDR_INT_MASK, 64'h1);
    wr(HTSR_ADDR_SLEEP_CFG, 64'h1);
    for (k = 0; k < 400 && sleep_enter !== 1'b1; k++) @(posedge sys_clk);
    #1 `CHK("sleep", 1'b1, sleep_enter)
    if (k == 400) close_out();
    `CHK("irq_masked", 1'b0, irq)
    wr(HTSR_ADDR_IDLE_TIME, 64'hffff);
    rd(HTSR_ADDR_IDLE_TIME);
    `CHK("idle_time", 16'hffff, q[15:0])
    rd(HTSR_ADDR_INT_STATUS);
    `CHK("sleep_evt", 1'b1, q[HTSR_INT_SLEEP])
    wr(HTSR_ADDR_INT_STATUS, 64'h7);
    rd(HTSR_ADDR_INT_STATUS);
    `CHK("w1c", 3'h0, q[2:0])
    $display("test sleep done");
    repeat (4) begin
      @(posedge sys_clk);
      lvl <= 13'($urandom);
      dir <= 13'($urandom);
      repeat (10) @(posedge sys_clk);
      rd(HTSR_ADDR_PIN_STATE);
      `CHK("pin_dir", {23'h0, dir[8:0]}, q[63:32])
      `CHK("pin_lvl", {19'h0, lvl[12], 3'h0, lvl[8:0]}, q[31:0])
    end
    b = q;
    wr(HTSR_ADDR_PIN_STATE, ~b);
    rd(HTSR_ADDR_PIN_STATE);
    `CHK("pin_ro", b, q)
    rd(8'h40);
    `CHK("unmapped", 64'h0, q)
    $display("test pins done");
    foreach (oc[i]) begin
      @(posedge sys_clk);
      cf_out <= 4'(oc[i]);
      cf_hi <= 4'($urandom);
      cf_pay <= {24'($urandom), $urandom};
      cf_dly <= 16'(20 + i * 5);
      #1 exp_q.push_back({cf_pay, (oc[i] inside {[1:4]}) ? 4'h0 : cf_hi, cf_out});
      wr(HTSR_ADDR_CMD, 64'h7461_736b);
      wr(HTSR_ADDR_CMD, 64'h1);
      rd(HTSR_ADDR_CMD);
      `CHK("cmd_hold", 32'h7461_736b, q[31:0])
      wait_cmd();
      rd(HTSR_ADDR_DATA);
      b = exp_q.pop_front();
      `CHK("result", b, q)
      `CHK("irq_done", 1'b1, irq)
      rd(HTSR_ADDR_INT_STATUS);
      `CHK("err_evt", oc[i] != 0, q[HTSR_INT_ERROR])
      wr(HTSR_ADDR_INT_STATUS, 64'h7);
      b = {$urandom, $urandom} & ~64'hf;
      wr(HTSR_ADDR_DATA, b);
      repeat (30) @(posedge sys_clk);
      rd(HTSR_ADDR_DATA);
      `CHK("data_hold", b, q)
      `CHK("irq_clear", 1'b0, irq)
    end
    $display("test tasks done");
    @(posedge sys_clk);
    needs_rx <= 1'b1;
    rx_lock <= 1'b1;
    cf_dly <= 16'd1000;
    wr(HTSR_ADDR_CMD, 64'h1);
    wait_cmd();
    rd(HTSR_ADDR_DATA);
    `CHK("rx_locked", {4'h0, HTSR_OUT_RX_LOCKED}, q[7:0])
    $display("test rx_locked done");
    close_out();
  end
endmodule
`default_nettype wire

/* File: verilog/htsr_pkg.sv */
// Package for the host task and status register bank.
// Assumes one 100 MHz clock domain and a simple strobe register port.
package htsr_pkg;
  // ----------------------------------------------------------------
  // Register map (byte index on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] HTSR_ADDR_CMD = 8'h08;
  localparam logic [7:0] HTSR_ADDR_DATA = 8'h09;
  localparam logic [7:0] HTSR_ADDR_INT_STATUS = 8'h14;
  localparam logic [7:0] HTSR_ADDR_INT_MASK = 8'h16;
  localparam logic [7:0] HTSR_ADDR_IDLE_TIME = 8'h18;
  localparam logic [7:0] HTSR_ADDR_SLEEP_CFG = 8'h70;
  localparam logic [7:0] HTSR_ADDR_PIN_STATE = 8'h72;
  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int HTSR_PERMIT_BIT = 0;
  localparam int HTSR_NUM_PINS = 13;
  localparam logic [12:0] HTSR_DIR_MASK = 13'h01ff;
  localparam logic [12:0] HTSR_LEVEL_MASK = 13'h11ff;
  localparam logic [7:0] HTSR_SLEEP_CFG_RST = 8'h01;
  localparam logic [15:0] HTSR_IDLE_TIME_RST = 16'h0064;
  localparam logic [31:0] HTSR_CMD_RST = 32'h0000_0000;
  localparam int HTSR_DATA_BYTES = 8;
  // Interrupt status bits
  localparam int HTSR_INT_DONE = 0;
  localparam int HTSR_INT_ERROR = 1;
  localparam int HTSR_INT_SLEEP = 2;
  localparam int HTSR_INT_BITS = 3;
  // ----------------------------------------------------------------
  // Task outcome codes
  // ----------------------------------------------------------------
  localparam logic [3:0] HTSR_OUT_SUCCESS = 4'h0;
  localparam logic [3:0] HTSR_OUT_ABORT = 4'h1;
  localparam logic [3:0] HTSR_OUT_REJECT = 4'h3;
  localparam logic [3:0] HTSR_OUT_RX_LOCKED = 4'h4;
  localparam logic [3:0] HTSR_OUT_ERR_LOW = 4'h5;
  // ----------------------------------------------------------------
  // Timing: idle interval tick of 1 us at 100 MHz
  // ----------------------------------------------------------------
  localparam int HTSR_CLK_MHZ = 100;
  localparam int HTSR_TICK_US = 1;
  localparam int HTSR_TICK_CYCLES = HTSR_TICK_US * HTSR_CLK_MHZ;
  typedef enum logic [1:0] {HTSR_IDLE, HTSR_RUN, HTSR_POST} htsr_task_t;
endpackage

/* File: verilog/htsr_regs.sv */
// Host task and status register bank: sleep permit, pin report, task slot.
// Assumes a task engine beside it that posts results through the done port,
// and pin signals from pads outside the clock domain.
//
// Function
// - Permit bit zero set allows sleep after idle interval; clear forbids sleep.
// - Sleep setup is one shared RW byte; upper seven bits reserved.
// - Pin report is eight read-only bytes; direction word bits 31:9 reserved.
// - Direction bits for pins zero to eight read one when pin is output.
// - Lower four bytes are level word; bits 31:13 and 11:9 reserved.
// - Level bits for pins zero to eight and twelve show sensed high.
// - Result data is written before the command slot is cleared to zero.
// - After the command clears, the data registers stay untouched.
// - Other registers may keep changing after a task completes.
// - Standard status goes in first data byte, outcome in bits 3:0.
// - Outcome zero success, one timeout or abort, three rejected, two reserved.
// - Task needing a locked receive buffer is rejected with code four.
// - Status bits 7:4 carry task codes; with success only when outcome zero; the bank also passes them for outcomes five and up.
// - Bytes after the status byte carry task-defined content.
`timescale 1ns/1ps
`default_nettype none
module htsr_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [63:0] reg_rdata,
  // Task engine side
  output logic [31:0] task_cmd,
  output logic task_start,
  input wire logic task_done,
  input wire logic [3:0] task_outcome,
  input wire logic [3:0] task_code_hi,
  input wire logic [55:0] task_payload,
  input wire logic task_needs_rx,
  input wire logic rx_buf_locked,
  input wire logic task_activity,
  // Pins
  input wire logic [htsr_pkg::HTSR_NUM_PINS-1:0] pin_level_in,
  input wire logic [htsr_pkg::HTSR_NUM_PINS-1:0] pin_dir_out,
  // Power and interrupt
  output logic sleep_enter,
  output logic irq
);
  import htsr_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] sleep_cfg;
  logic [15:0] idle_time;
  logic [31:0] cmd;
  logic [63:0] data;
  logic [HTSR_INT_BITS-1:0] int_status;
  logic [HTSR_INT_BITS-1:0] int_mask;
  logic [HTSR_INT_BITS-1:0] int_event;
  htsr_task_t state;
  logic [HTSR_NUM_PINS-1:0] lvl_s1, lvl_s2, lvl_s3, lvl_q;
  logic [HTSR_NUM_PINS-1:0] dir_s1, dir_s2, dir_s3, dir_q;
  logic [6:0] tick_cnt;
  logic tick;
  logic [15:0] idle_cnt;
  logic sleeping;
  logic [7:0] status_byte;
  logic [3:0] next_outcome;
  logic [3:0] next_hi;
  logic cmd_write;
  logic data_write;
  logic status_write;
  logic mask_write;
  logic idle_write;
  logic cfg_write;
  logic done_evt;
  logic busy_now;
  logic [63:0] next_data;
  logic [31:0] dir_word;
  logic [31:0] lvl_word;
  logic [63:0] next_rdata;

  // A task that needs a locked receive buffer ends at once; the engine is still started, but its done is not awaited
  assign done_evt = (state == HTSR_RUN) && (task_done || (task_needs_rx && rx_buf_locked));

  // ----------------------------------------------------------------
  // Write decode: at most one register strobe per bus write
  // ----------------------------------------------------------------
  // Writes to the pin report or to unmapped offsets select nothing
  always_comb begin
    cmd_write = 1'b0;
    data_write = 1'b0;
    status_write = 1'b0;
    mask_write = 1'b0;
    idle_write = 1'b0;
    cfg_write = 1'b0;
    if (reg_wr) begin
      if (reg_addr == HTSR_ADDR_CMD) begin
        cmd_write = 1'b1;
      end else if (reg_addr == HTSR_ADDR_DATA) begin
        data_write = 1'b1;
      end else if (reg_addr == HTSR_ADDR_INT_STATUS) begin
        status_write = 1'b1;
      end else if (reg_addr == HTSR_ADDR_INT_MASK) begin
        mask_write = 1'b1;
      end else if (reg_addr == HTSR_ADDR_IDLE_TIME) begin
        idle_write = 1'b1;
      end else if (reg_addr == HTSR_ADDR_SLEEP_CFG) begin
        cfg_write = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, change taken when 2 and 3 agree
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < HTSR_NUM_PINS; gi = gi + 1) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          lvl_s1[gi] <= 1'b0;
          lvl_s2[gi] <= 1'b0;
          lvl_s3[gi] <= 1'b0;
          lvl_q[gi] <= 1'b0;
          dir_s1[gi] <= 1'b0;
          dir_s2[gi] <= 1'b0;
          dir_s3[gi] <= 1'b0;
          dir_q[gi] <= 1'b0;
        end else begin
          lvl_s1[gi] <= pin_level_in[gi];
          lvl_s2[gi] <= lvl_s1[gi];
          lvl_s3[gi] <= lvl_s2[gi];
          if (lvl_s2[gi] == lvl_s3[gi]) begin
            lvl_q[gi] <= lvl_s3[gi];
          end
          dir_s1[gi] <= pin_dir_out[gi];
          dir_s2[gi] <= dir_s1[gi];
          dir_s3[gi] <= dir_s2[gi];
          if (dir_s2[gi] == dir_s3[gi]) begin
            dir_q[gi] <= dir_s3[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Power-saving setup and idle interval
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sleep_cfg <= HTSR_SLEEP_CFG_RST;
      idle_time <= HTSR_IDLE_TIME_RST;
    end else if (cfg_write) begin
      // Reserved bits are dropped on write so they always read as zero
      sleep_cfg <= {7'h00, reg_wdata[HTSR_PERMIT_BIT]};
    end else if (idle_write) begin
      idle_time <= reg_wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Microsecond tick: a one-cycle enable for the idle counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_cnt <= 7'h00;
      tick <= 1'b0;
    end else if (tick_cnt == 7'(HTSR_TICK_CYCLES - 1)) begin
      tick_cnt <= 7'h00;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 7'h01;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Idle detection and sleep request
  // ----------------------------------------------------------------
  // Any bus access, running task or engine activity counts as busy, so a
  // host that keeps polling the bank also keeps the device awake
  assign busy_now = !sleep_cfg[HTSR_PERMIT_BIT] || reg_wr || reg_rd ||
                    task_activity || (state != HTSR_IDLE);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idle_cnt <= 16'h0000;
    end else if (busy_now) begin
      idle_cnt <= 16'h0000;
    end else if (tick && idle_cnt < idle_time) begin
      idle_cnt <= idle_cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sleeping <= 1'b0;
    end else if (busy_now) begin
      sleeping <= 1'b0;
    end else if (idle_cnt >= idle_time) begin
      sleeping <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sleep_enter <= 1'b0;
    end else begin
      sleep_enter <= sleeping;
    end
  end

  // ----------------------------------------------------------------
  // Task slot: command, data and completion sequence
  // ----------------------------------------------------------------
  always_comb begin
    if (task_needs_rx && rx_buf_locked) begin
      next_outcome = HTSR_OUT_RX_LOCKED;
      next_hi = 4'h0;
    end else begin
      next_outcome = task_outcome;
      // Upper nibble passed for outcome zero and for outcomes five and up, cleared for one to four
      next_hi = (task_outcome == HTSR_OUT_SUCCESS || task_outcome >= HTSR_OUT_ERR_LOW) ?
                task_code_hi : 4'h0;
    end
    status_byte = {next_hi, next_outcome};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= HTSR_IDLE;
    end else begin
      case (state)
        HTSR_IDLE: begin
          if (cmd_write && reg_wdata[31:0] != 32'h0000_0000) begin
            state <= HTSR_RUN;
          end
        end
        HTSR_RUN: begin
          if (done_evt) begin
            state <= HTSR_POST;
          end
        end
        HTSR_POST: begin
          state <= HTSR_IDLE;
        end
        default: begin
          state <= HTSR_IDLE;
        end
      endcase
    end
  end

  // A write while a task runs or posts is ignored, so one start per task
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      task_start <= 1'b0;
    end else begin
      task_start <= (state == HTSR_IDLE) && cmd_write && (reg_wdata[31:0] != 32'h0000_0000);
    end
  end

  // Command slot cleared one cycle after data is posted
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd <= HTSR_CMD_RST;
    end else if (state == HTSR_POST) begin
      cmd <= 32'h0000_0000;
    end else if (state == HTSR_IDLE && cmd_write) begin
      cmd <= reg_wdata[31:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      task_cmd <= HTSR_CMD_RST;
    end else begin
      task_cmd <= cmd;
    end
  end

  // Data only changes by the host while idle or by the posting step
  always_comb begin
    next_data = data;
    if (done_evt) begin
      next_data = {task_payload, status_byte};
    end else if (state == HTSR_IDLE && data_write) begin
      next_data = reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data <= 64'h0;
    end else begin
      data <= next_data;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  always_comb begin
    int_event = '0;
    int_event[HTSR_INT_DONE] = (state == HTSR_POST);
    int_event[HTSR_INT_ERROR] = done_evt && (status_byte[3:0] != HTSR_OUT_SUCCESS);
    int_event[HTSR_INT_SLEEP] = sleeping && !sleep_enter;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_status <= '0;
    end else if (status_write) begin
      int_status <= (int_status & ~reg_wdata[HTSR_INT_BITS-1:0]) | int_event;
    end else begin
      int_status <= int_status | int_event;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_mask <= '0;
    end else if (mask_write) begin
      int_mask <= reg_wdata[HTSR_INT_BITS-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read port: data one cycle after the read strobe, else zero
  // ----------------------------------------------------------------
  // Reserved bits of both pin words read low: 31:13 are tied, the rest are masked off
  assign dir_word = {19'h0, dir_q & HTSR_DIR_MASK};
  assign lvl_word = {19'h0, lvl_q & HTSR_LEVEL_MASK};

  always_comb begin
    next_rdata = 64'h0;
    if (!reg_rd) begin
      next_rdata = 64'h0;
    end else if (reg_addr == HTSR_ADDR_SLEEP_CFG) begin
      next_rdata = {56'h0, sleep_cfg};
    end else if (reg_addr == HTSR_ADDR_PIN_STATE) begin
      next_rdata = {dir_word, lvl_word};
    end else if (reg_addr == HTSR_ADDR_CMD) begin
      next_rdata = {32'h0, cmd};
    end else if (reg_addr == HTSR_ADDR_DATA) begin
      next_rdata = data;
    end else if (reg_addr == HTSR_ADDR_INT_STATUS) begin
      next_rdata = {61'h0, int_status};
    end else if (reg_addr == HTSR_ADDR_INT_MASK) begin
      next_rdata = {61'h0, int_mask};
    end else if (reg_addr == HTSR_ADDR_IDLE_TIME) begin
      next_rdata = {48'h0, idle_time};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 64'h0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire
